// ==== hdl/aiob_pkg.sv ====
// package of the auxiliary-line, busy, trigger and alarm block
// shared by the serial frame engine and the top module; no timescale needed
package aiob_pkg;

  // ------------------------------------------------------------
  // register byte addresses (7-bit serial address field)
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_FLASH_WRITE_COUNT   = 7'h00;
  localparam logic [6:0] ADDR_ALARM_CONTROL       = 7'h34;
  localparam logic [6:0] ADDR_AUX_LINE_CONFIG     = 7'h36;
  localparam logic [6:0] ADDR_GPIO_CONTROL        = 7'h38;
  localparam logic [6:0] ADDR_DIAGNOSTIC_FLAG     = 7'h3c;
  localparam logic [6:0] ADDR_GLOBAL_COMMAND      = 7'h3e;
  localparam logic [6:0] ADDR_LOT_IDENTIFIER_HIGH = 7'h54;
  localparam logic [6:0] ADDR_PRODUCT_IDENTIFIER  = 7'h56;
  localparam logic [6:0] ADDR_UNIT_SERIAL_NUMBER  = 7'h58;
  localparam logic [6:0] ADDR_USER_IDENTIFIER     = 7'h5c;

  // ------------------------------------------------------------
  // special command words
  // ------------------------------------------------------------
  localparam logic [15:0] CMD_ESCAPE_WORD    = 16'he8e8;
  localparam logic [15:0] CMD_DIAG_READ_WORD = 16'h3c00;
  localparam int          CMD_WRITE_BIT      = 15;
  localparam logic [4:0]  SPI_FRAME_BITS     = 5'h10;

  // ------------------------------------------------------------
  // auxiliary line configuration fields
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    AIOB_FN_GPIO    = 2'b00,
    AIOB_FN_ALARM   = 2'b01,
    AIOB_FN_TRIGGER = 2'b10,
    AIOB_FN_BUSY    = 2'b11
  } aiob_fn_type;

  localparam int         AUX_POL_LSB      = 0;
  localparam int         AUX_FN_LSB       = 2;
  localparam logic [7:0] AUX_CONFIG_RESET = 8'h0d;

  // ------------------------------------------------------------
  // other register fields and reset values
  // ------------------------------------------------------------
  localparam int GCMD_SELFTEST_BIT   = 2;
  localparam int GCMD_FLAG_CLEAR_BIT = 4;
  localparam int GCMD_CHECKSUM_BIT   = 5;
  localparam int DIAG_SPI_ERR_BIT    = 3;
  localparam int DIAG_SELFTEST_BIT   = 5;
  localparam int DIAG_CHECKSUM_BIT   = 6;
  localparam int DIAG_READY_BIT      = 7;
  localparam int DIAG_ALARM_LSB      = 8;
  localparam int DIAG_ALARM_ONE_MSB  = 10;
  localparam int DIAG_ALARM_TWO_LSB  = 11;
  localparam int DIAG_ALARM_MSB      = 13;
  localparam int ALARM_SPLIT_BIT     = 6;
  localparam int GPIO_DIR_LSB        = 0;
  localparam int GPIO_LEVEL_LSB      = 8;

  localparam logic [15:0] FLASH_COUNT_RESET   = 16'h0000;
  localparam logic [15:0] ALARM_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] GPIO_CONTROL_RESET  = 16'h0000;
  localparam logic [15:0] GLOBAL_CMD_RESET    = 16'h0000;
  localparam logic [15:0] DIAG_FLAG_RESET     = 16'h0000;
  localparam logic [15:0] USER_IDENTIFIER_RESET       = 16'h0000;

endpackage : aiob_pkg

// ==== hdl/aiob_spi_frame.sv ====
// serial frame engine: 16-bit frames, clock idles high, sample on rising edge
// assumes sclk at most one eighth of clock_i; pins arrive unsynchronised
`timescale 1ns/1ps
module aiob_spi_frame (
  input  wire logic        clock_i,     // system clock
  input  wire logic        rst_n_i,     // synchronised reset, active low
  input  wire logic        sclk_i,      // serial clock pin
  input  wire logic        cs_n_i,      // chip select pin, active low
  input  wire logic        din_i,       // serial data in pin
  input  wire logic [15:0] tx_word_i,   // word shifted out next frame
  output logic             dout_o,      // serial data out
  output logic             frame_o,     // pulse: full frame received
  output logic             frame_err_o, // pulse: frame neither 0 nor 16 clocks
  output logic [15:0]      rx_word_o    // last received word
);
  import aiob_pkg::*;

  logic [2:0]  sync_a_q;
  logic [2:0]  sync_b_q;
  logic        sclk_prev_q;
  logic        cs_prev_q;
  logic [15:0] rx_sh_q;
  logic [15:0] tx_sh_q;
  logic [4:0]  bit_cnt_q;
  wire         sclk_w     = sync_b_q[0];
  wire         cs_n_w     = sync_b_q[1];
  wire         din_w      = sync_b_q[2];
  wire         sclk_rise  = sclk_w & ~sclk_prev_q & ~cs_n_w;
  wire         sclk_fall  = ~sclk_w & sclk_prev_q & ~cs_n_w;
  wire         cs_fall    = ~cs_n_w & cs_prev_q;
  wire         cs_rise    = cs_n_w & ~cs_prev_q;
  wire         cnt_full   = &bit_cnt_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a_q    <= 3'h3;
      sync_b_q    <= 3'h3;
      sclk_prev_q <= 1'b1;
      cs_prev_q   <= 1'b1;
      rx_sh_q     <= 16'h0000;
      tx_sh_q     <= 16'h0000;
      bit_cnt_q   <= 5'h00;
      dout_o      <= 1'b0;
      frame_o     <= 1'b0;
      frame_err_o <= 1'b0;
      rx_word_o   <= 16'h0000;
    end else begin
      sync_a_q    <= {din_i, cs_n_i, sclk_i};
      sync_b_q    <= sync_a_q;
      sclk_prev_q <= sclk_w;
      cs_prev_q   <= cs_n_w;
      dout_o      <= tx_sh_q[15];
      frame_o     <= 1'b0;
      frame_err_o <= 1'b0;
      if (sclk_fall && bit_cnt_q != 5'h00) begin
        tx_sh_q <= {tx_sh_q[14:0], 1'b0};
      end
      if (sclk_rise) begin
        rx_sh_q <= {rx_sh_q[14:0], din_w};
        if (!cnt_full) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
      end
      if (cs_fall) begin
        tx_sh_q   <= tx_word_i;
        bit_cnt_q <= 5'h00;
      end
      if (cs_rise) begin
        if (bit_cnt_q == SPI_FRAME_BITS) begin
          frame_o   <= 1'b1;
          rx_word_o <= rx_sh_q;
        end else if (bit_cnt_q != 5'h00) begin
          frame_err_o <= 1'b1;
        end
      end
    end
  end

endmodule : aiob_spi_frame

// ==== hdl/aiob_top.sv ====
// top of the auxiliary-line block: registers, busy, escape, trigger, alarms
// assumes capture, self-test and flash engines on clock_i drive the engine ports
//
// What this block does
// - during capture only escape and diag read act, escape stops capture
// - busy line active when recording or commanding
// - reset config: line one busy, active high
// - config 0x2f: line two trigger input
// - trigger after active then release edge (rise then fall when active high); start on release
// - config bits 5:2 select alarm from flags 13:8
// - config 0x12: line two alarm, active high
// - split alarm control: line one alarm one, two two
// - flag clear command clears flags, alarm lines idle
// - gpio direction, output level, sampled input level
// - command bit 2 runs self-test, result bit 5
// - command bit 5 runs flash checksum, bit 6
// - read-only 16-bit flash write counter
// - writable readable user identifier register
// - diagnostic bit 7 low busy, high idle
// - while busy only diag read and escape
// - command bits self-clear when function completes
`timescale 1ns/1ps
module aiob_top #(
  parameter logic [15:0] LOT_ID_HIGH_VALUE = 16'h1234, // value arbitrary
  parameter logic [15:0] PRODUCT_ID_VALUE  = 16'h5a5a, // value arbitrary
  parameter logic [15:0] SERIAL_NUM_VALUE  = 16'h0001  // value arbitrary
) (
  input  wire logic       clock_i,            // 50 MHz system clock
  input  wire logic       nrst_i,             // async reset, active low
  input  wire logic       spi_sclk_i,         // serial clock pin
  input  wire logic       spi_cs_n_i,         // chip select pin
  input  wire logic       spi_din_i,          // serial data in pin
  output logic            spi_dout_o,         // serial data out pin
  input  wire logic [1:0] aux_line_in_i,      // aux line pin levels
  output logic [1:0]      aux_line_out_o,     // aux line drive levels
  output logic [1:0]      aux_line_oe_o,      // aux line drive enables
  input  wire logic       capture_active_i,   // capture engine recording
  output logic            capture_escape_o,   // pulse: stop capture
  output logic            capture_trigger_o,  // pulse: start recording
  input  wire logic [5:0] alarm_flag_set_i,   // pulses: alarm flags 13:8
  output logic            selftest_start_o,   // pulse: start self-test
  input  wire logic       selftest_done_i,    // pulse: self-test finished
  input  wire logic       selftest_fail_i,    // self-test result with done
  output logic            checksum_start_o,   // pulse: start flash checksum
  input  wire logic       checksum_done_i,    // pulse: checksum finished
  input  wire logic       checksum_fail_i,    // checksum result with done
  input  wire logic       flash_write_i       // pulse: one flash write cycle
);
  import aiob_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync_q;
  wire        rst_n = rst_sync_q[1];

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic addr_hit(input logic [6:0] addr, input logic [6:0] reg_addr);
    addr_hit = (addr[6:1] == reg_addr[6:1]);
  endfunction : addr_hit

  function automatic logic [15:0] byte_merge(input logic [15:0] old, input logic hi, input logic [7:0] data);
    byte_merge = hi ? {data, old[7:0]} : {old[15:8], data};
  endfunction : byte_merge

  // ------------------------------------------------------------
  // serial port
  // ------------------------------------------------------------
  logic [15:0] tx_word_q;
  logic        frame_w;
  logic        frame_err_w;
  logic [15:0] rx_word_w;

  aiob_spi_frame u_spi (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n),
    .sclk_i      (spi_sclk_i),
    .cs_n_i      (spi_cs_n_i),
    .din_i       (spi_din_i),
    .tx_word_i   (tx_word_q),
    .dout_o      (spi_dout_o),
    .frame_o     (frame_w),
    .frame_err_o (frame_err_w),
    .rx_word_o   (rx_word_w)
  );

  // ------------------------------------------------------------
  // registers and command decode
  // ------------------------------------------------------------
  logic [7:0]  aux_line_config_q;
  logic [15:0] alarm_control_q;
  logic [15:0] gpio_control_q;
  logic [15:0] global_command_q;
  logic [15:0] diagnostic_flag_q;
  logic [15:0] flash_write_count_q;
  logic [15:0] user_identifier_q;
  logic        capture_prev_q;
  logic [1:0]  aux_sync_a_q;
  logic [1:0]  aux_sync_b_q;

  wire         cmd_write    = rx_word_w[CMD_WRITE_BIT];
  wire [6:0]   cmd_addr     = rx_word_w[14:8];
  wire [7:0]   cmd_data     = rx_word_w[7:0];
  wire         busy_w       = capture_active_i | (|global_command_q);
  wire         is_escape    = frame_w & (rx_word_w == CMD_ESCAPE_WORD);
  wire         is_diag_read = frame_w & (rx_word_w == CMD_DIAG_READ_WORD);
  wire         cmd_accept   = frame_w & ~busy_w;
  wire         wr_accept    = cmd_accept & cmd_write;
  wire         rd_accept    = (cmd_accept & ~cmd_write) | is_diag_read;
  wire         escape_act   = is_escape & capture_active_i;
  wire         wr_hi        = cmd_addr[0];
  wire         wr_aux_cfg   = wr_accept & addr_hit(cmd_addr, ADDR_AUX_LINE_CONFIG) & ~wr_hi;
  wire         wr_alarm_ctl = wr_accept & addr_hit(cmd_addr, ADDR_ALARM_CONTROL);
  wire         wr_gpio_ctl  = wr_accept & addr_hit(cmd_addr, ADDR_GPIO_CONTROL);
  wire         wr_user_identifier   = wr_accept & addr_hit(cmd_addr, ADDR_USER_IDENTIFIER);
  wire         wr_global_command_reg  = wr_accept & addr_hit(cmd_addr, ADDR_GLOBAL_COMMAND);
  wire [15:0]  gcmd_written = wr_global_command_reg ? byte_merge(16'h0000, wr_hi, cmd_data) : 16'h0000;
  wire         flag_clear   = gcmd_written[GCMD_FLAG_CLEAR_BIT];
  wire         capture_rise = capture_active_i & ~capture_prev_q;
  wire         flags_reset  = flag_clear | capture_rise;

  // command bits: self-test and checksum stay until their engine reports done
  wire [15:0]  gcmd_keep_w  = (16'h0001 << GCMD_SELFTEST_BIT) | (16'h0001 << GCMD_CHECKSUM_BIT);
  wire [15:0]  gcmd_done_w  = ({15'h0000, selftest_done_i} << GCMD_SELFTEST_BIT)
                            | ({15'h0000, checksum_done_i} << GCMD_CHECKSUM_BIT);
  wire [15:0]  gcmd_d       = (global_command_q & gcmd_keep_w & ~gcmd_done_w) | gcmd_written;

  // ------------------------------------------------------------
  // diagnostic flags: hardware set wins over clear
  // ------------------------------------------------------------
  wire [5:0]   alarm_flags_q = diagnostic_flag_q[DIAG_ALARM_MSB:DIAG_ALARM_LSB];
  wire [5:0]   alarm_flags_d = alarm_flag_set_i | (flags_reset ? 6'h00 : alarm_flags_q);
  wire         spi_err_d     = frame_err_w | (~flags_reset & diagnostic_flag_q[DIAG_SPI_ERR_BIT]);
  wire         selftest_d    = selftest_done_i ? selftest_fail_i
                             : (~flags_reset & diagnostic_flag_q[DIAG_SELFTEST_BIT]);
  wire         checksum_d    = checksum_done_i ? checksum_fail_i
                             : (~flags_reset & diagnostic_flag_q[DIAG_CHECKSUM_BIT]);
  wire [15:0]  diag_d        = {2'h0, alarm_flags_d, 1'b0, checksum_d, selftest_d,
                                1'b0, spi_err_d, 3'h0};
  wire [15:0]  diag_read_w   = diagnostic_flag_q | ({15'h0000, ~busy_w} << DIAG_READY_BIT);

  // ------------------------------------------------------------
  // auxiliary line function decode
  // ------------------------------------------------------------
  wire         alarm_any   = |alarm_flags_q;
  wire         alarm_one   = |diagnostic_flag_q[DIAG_ALARM_ONE_MSB:DIAG_ALARM_LSB];
  wire         alarm_two   = |diagnostic_flag_q[DIAG_ALARM_MSB:DIAG_ALARM_TWO_LSB];
  wire         alarm_split = alarm_control_q[ALARM_SPLIT_BIT];
  wire [1:0]   alarm_line  = alarm_split ? {alarm_two, alarm_one} : {2{alarm_any}};
  wire [1:0]   gpio_dir    = gpio_control_q[GPIO_DIR_LSB +: 2];
  wire [1:0]   gpio_level  = gpio_control_q[GPIO_LEVEL_LSB +: 2];

  logic [1:0]  line_out_d;
  logic [1:0]  line_oe_d;
  logic [1:0]  trig_in_w;
  logic [1:0]  trig_prev_q;
  logic [1:0]  trig_armed_q;
  logic [1:0]  trig_armed_d;
  logic [1:0]  trig_fire_w;
  logic [1:0]  gpio_read_level;

  for (genvar i = 0; i < 2; i++) begin : g_line
    aiob_fn_type fn_w;
    wire         pol_w = aux_line_config_q[AUX_POL_LSB + i];
    wire         act_w;
    assign fn_w  = aiob_fn_type'(aux_line_config_q[AUX_FN_LSB + 2*i +: 2]);
    assign act_w = (fn_w == AIOB_FN_BUSY) ? busy_w : alarm_line[i];
    assign line_out_d[i] = (fn_w == AIOB_FN_GPIO) ? gpio_level[i] : (act_w ~^ pol_w);
    assign line_oe_d[i]  = (fn_w == AIOB_FN_BUSY) | (fn_w == AIOB_FN_ALARM)
                         | ((fn_w == AIOB_FN_GPIO) & gpio_dir[i]);
    assign gpio_read_level[i] = gpio_dir[i] ? gpio_level[i] : aux_sync_b_q[i];
    // trigger: arm on active edge, fire on release edge
    assign trig_in_w[i]    = (aux_sync_b_q[i] ~^ pol_w) & (fn_w == AIOB_FN_TRIGGER);
    assign trig_fire_w[i]  = trig_armed_q[i] & trig_prev_q[i] & ~trig_in_w[i];
    assign trig_armed_d[i] = (trig_in_w[i] & ~trig_prev_q[i]) | (trig_armed_q[i] & ~trig_fire_w[i]);
  end

  // host keeps trigger pulses long enough to pass the pin synchroniser
  wire         trigger_go = (|trig_fire_w) & ~busy_w;

  // ------------------------------------------------------------
  // read data select
  // ------------------------------------------------------------
  wire [6:0]   rd_addr   = cmd_addr;
  wire [15:0]  gpio_rd_w = {gpio_control_q[15:GPIO_LEVEL_LSB + 2], gpio_read_level,
                            gpio_control_q[GPIO_LEVEL_LSB - 1:0]};
  wire [15:0]  rd_data_w =
      addr_hit(rd_addr, ADDR_FLASH_WRITE_COUNT)   ? flash_write_count_q :
      addr_hit(rd_addr, ADDR_ALARM_CONTROL)       ? alarm_control_q :
      addr_hit(rd_addr, ADDR_AUX_LINE_CONFIG)     ? {8'h00, aux_line_config_q} :
      addr_hit(rd_addr, ADDR_GPIO_CONTROL)        ? gpio_rd_w :
      addr_hit(rd_addr, ADDR_DIAGNOSTIC_FLAG)     ? diag_read_w :
      addr_hit(rd_addr, ADDR_GLOBAL_COMMAND)      ? global_command_q :
      addr_hit(rd_addr, ADDR_LOT_IDENTIFIER_HIGH) ? LOT_ID_HIGH_VALUE :
      addr_hit(rd_addr, ADDR_PRODUCT_IDENTIFIER)  ? PRODUCT_ID_VALUE :
      addr_hit(rd_addr, ADDR_UNIT_SERIAL_NUMBER)  ? SERIAL_NUM_VALUE :
      addr_hit(rd_addr, ADDR_USER_IDENTIFIER)     ? user_identifier_q : 16'h0000;

  // ------------------------------------------------------------
  // pin synchroniser for the aux lines
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      aux_sync_a_q <= 2'h0;
      aux_sync_b_q <= 2'h0;
    end else begin
      aux_sync_a_q <= aux_line_in_i;
      aux_sync_b_q <= aux_sync_a_q;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      aux_line_config_q <= AUX_CONFIG_RESET;
      alarm_control_q   <= ALARM_CONTROL_RESET;
      gpio_control_q    <= GPIO_CONTROL_RESET;
      user_identifier_q <= USER_IDENTIFIER_RESET;
    end else begin
      if (wr_aux_cfg) begin
        aux_line_config_q <= cmd_data;
      end
      if (wr_alarm_ctl) begin
        alarm_control_q <= byte_merge(alarm_control_q, wr_hi, cmd_data);
      end
      if (wr_gpio_ctl) begin
        gpio_control_q <= byte_merge(gpio_control_q, wr_hi, cmd_data);
      end
      if (wr_user_identifier) begin
        user_identifier_q <= byte_merge(user_identifier_q, wr_hi, cmd_data);
      end
    end
  end

  // ------------------------------------------------------------
  // commands, flags and counter
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      global_command_q    <= GLOBAL_CMD_RESET;
      diagnostic_flag_q   <= DIAG_FLAG_RESET;
      flash_write_count_q <= FLASH_COUNT_RESET;
      capture_prev_q      <= 1'b0;
    end else begin
      global_command_q  <= gcmd_d;
      diagnostic_flag_q <= diag_d;
      capture_prev_q    <= capture_active_i;
      if (flash_write_i) begin
        flash_write_count_q <= flash_write_count_q + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // trigger detector and response word
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev_q  <= 2'h0;
      trig_armed_q <= 2'h0;
      tx_word_q    <= 16'h0000;
    end else begin
      trig_prev_q  <= trig_in_w;
      trig_armed_q <= trig_armed_d;
      if (rd_accept) begin
        tx_word_q <= rd_data_w;
      end
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      aux_line_out_o    <= 2'h0;
      aux_line_oe_o     <= 2'h0;
      capture_escape_o  <= 1'b0;
      capture_trigger_o <= 1'b0;
      selftest_start_o  <= 1'b0;
      checksum_start_o  <= 1'b0;
    end else begin
      aux_line_out_o    <= line_out_d;
      aux_line_oe_o     <= line_oe_d;
      capture_escape_o  <= escape_act;
      capture_trigger_o <= trigger_go;
      selftest_start_o  <= gcmd_written[GCMD_SELFTEST_BIT];
      checksum_start_o  <= gcmd_written[GCMD_CHECKSUM_BIT];
    end
  end

endmodule : aiob_top

// ==== testbench/aiob_top_sva.sv ====
// checker: escape, trigger and command pulses of aiob_top
// assumes bind onto aiob_top, signals taken by port name
`timescale 1ns/1ps
module aiob_top_sva (
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic       capture_active_i,
  input wire logic       capture_escape_o,
  input wire logic       capture_trigger_o,
  input wire logic       selftest_start_o,
  input wire logic       checksum_start_o,
  input wire logic [1:0] aux_line_in_i,
  input wire logic [1:0] aux_line_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence capturing; capture_active_i [*4]; endsequence
  chk_escape_cause: assert property (
    capture_escape_o |-> capture_active_i || $past(capture_active_i)) else $error("escape without capture");
  chk_escape_single: assert property (capture_escape_o |=> !capture_escape_o) else $error("escape pulse long");
  chk_trig_single: assert property (capture_trigger_o |=> !capture_trigger_o) else $error("trigger pulse long");
  chk_trig_input: assert property (
    capture_trigger_o |-> aux_line_oe_o != 2'b11 && aux_line_in_i != 2'b11) else $error("trigger without low input");
  chk_selftest_single: assert property (selftest_start_o |=> !selftest_start_o) else $error("self-test pulse long");
  chk_checksum_single: assert property (checksum_start_o |=> !checksum_start_o) else $error("checksum pulse long");
  chk_busy_no_cmd: assert property (
    capturing |-> !selftest_start_o && !checksum_start_o) else $error("command started while capturing");
  chk_busy_no_trig: assert property (capturing |-> !capture_trigger_o) else $error("trigger while capturing");
endmodule : aiob_top_sva
bind aiob_top aiob_top_sva aiob_top_sva_i (.clock_i(clock_i), .nrst_i(nrst_i), .capture_active_i(capture_active_i),
  .capture_escape_o(capture_escape_o), .capture_trigger_o(capture_trigger_o), .selftest_start_o(selftest_start_o),
  .checksum_start_o(checksum_start_o), .aux_line_in_i(aux_line_in_i), .aux_line_oe_o(aux_line_oe_o));

// ==== testbench/aiob_host_model.sv ====
// host model: serial master, 16-bit frames, clock idles high
// assumes caller enters tasks just after a rising clock_i edge
`timescale 1ns/1ps
module aiob_host_model (
  input  wire logic clock_i,         // system clock
  input  wire logic spi_dout_i,      // device serial out
  output logic      spi_sclk_o = 1,  // serial clock
  output logic      spi_cs_n_o = 1,  // chip select, active low
  output logic      spi_din_o  = 0   // serial data to device
);
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(posedge clock_i) spi_cs_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (4) @(posedge clock_i);
      spi_sclk_o <= 1'b0;
      spi_din_o  <= w[i];
      // device output settles four clocks after sclk falls
      repeat (5) @(posedge clock_i);
      r[i] = spi_dout_i;
      spi_sclk_o <= 1'b1;
    end
    repeat (4) @(posedge clock_i);
    spi_cs_n_o <= 1'b1;
    spi_din_o  <= ~w[0];  // released line shows no stale bit
    repeat (8) @(posedge clock_i);
  endtask : xfer
endmodule : aiob_host_model

// ==== testbench/aiob_top_tb_top.sv ====
// testbench: drives aiob_top through the host model, checks ports
// assumes 50 MHz clock_i; aux pins resolved from drive enables
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
module aiob_top_tb_top;
  import aiob_pkg::*;
  logic        clock_i = 0, nrst_i = 0, cap_q = 0, fail_q = 0, fw_q = 0, sclk, cs_n, din, dout, esc, trg, st_go, ck_go;
  logic [1:0]  ext_q = 0, done_q = 0, pin, out, oe;
  logic [5:0]  set_q = 0;
  logic [15:0] d;
  int          error_cnt = 0, check_count = 0, cyc = 0, esc_n = 0, trg_n = 0, st_n = 0, n = 0;
  always #10 clock_i = ~clock_i;
  assign pin = (oe & out) | (~oe & ext_q);
  aiob_host_model aiob_host_model_i (.clock_i(clock_i), .spi_dout_i(dout), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n),
    .spi_din_o(din));
  aiob_top #(.PRODUCT_ID_VALUE(16'h0c0d)) aiob_top_i (.clock_i(clock_i), .nrst_i(nrst_i), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_din_i(din), .spi_dout_o(dout), .aux_line_in_i(pin), .aux_line_out_o(out),
    .aux_line_oe_o(oe), .capture_active_i(cap_q), .capture_escape_o(esc), .capture_trigger_o(trg),
    .alarm_flag_set_i(set_q), .selftest_start_o(st_go), .selftest_done_i(done_q[0]), .selftest_fail_i(fail_q),
    .checksum_start_o(ck_go), .checksum_done_i(done_q[1]), .checksum_fail_i(fail_q), .flash_write_i(fw_q));
  always @(posedge clock_i) begin
    cyc   <= cyc + 1;
    esc_n <= esc_n + esc;
    trg_n <= trg_n + trg;
    st_n  <= st_n + st_go + ck_go;
    if (esc) cap_q <= 1'b0;  // capture engine stops on escape
    if (cyc == 30000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic wr(input logic [15:0] w);
    logic [15:0] r;
    aiob_host_model_i.xfer(w, r);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    aiob_host_model_i.xfer({1'b0, a, 8'h00}, d);
    aiob_host_model_i.xfer(CMD_DIAG_READ_WORD, d);
  endtask : rd
  task automatic cmd(input int k, input logic f);
    wr(k ? 16'hbe20 : 16'hbe04);
    rd(ADDR_DIAGNOSTIC_FLAG);
    `CHK("ready busy", 1'b0, d[DIAG_READY_BIT])
    @(posedge clock_i) begin
      done_q[k] <= 1'b1;
      fail_q    <= f;
    end
    @(posedge clock_i) done_q <= 2'b00;
    rd(ADDR_DIAGNOSTIC_FLAG);
    `CHK("result", {1'b1, f}, {d[DIAG_READY_BIT], d[5+k]})
    rd(ADDR_GLOBAL_COMMAND);
    `CHK("cmd clear", 16'h0000, d)
  endtask : cmd
  task automatic alarm(input logic [5:0] s, input logic [1:0] e);
    @(posedge clock_i) set_q <= s;
    @(posedge clock_i) set_q <= 6'h00;
    repeat (4) @(posedge clock_i);
    `CHK("alarm", e, out & oe)
    wr(16'hbe10);
    `CHK("alarm clear", 2'b00, out)
  endtask : alarm
  initial begin
    repeat (5) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    `CHK("reset lines", 4'b0100, {oe, out})
    cap_q <= 1'b1;
    wr(16'hb600); // refused while busy
    wr(16'hbe04);
    `CHK("busy line", 1'b1, out[0])
    rd(ADDR_DIAGNOSTIC_FLAG);
    while (d[DIAG_READY_BIT] !== 1'b1 && n < 5) begin  // escape until idle
      wr(CMD_ESCAPE_WORD);
      repeat (2500) @(posedge clock_i);
      rd(ADDR_DIAGNOSTIC_FLAG);
      n++;
    end
    `CHK("escapes", 1, esc_n)
    `CHK("starts", 0, st_n)
    $display("test escape done");
    repeat (3) @(posedge clock_i) fw_q <= ~fw_q;
    @(posedge clock_i) fw_q <= 1'b0;
    wr(16'h8055);
    wr(16'hdca5);
    wr(16'hddc3);
    rd(ADDR_FLASH_WRITE_COUNT);
    `CHK("flash count", 16'h0002, d)
    rd(ADDR_USER_IDENTIFIER);
    `CHK("user_identifier", 16'hc3a5, d)
    rd(ADDR_PRODUCT_IDENTIFIER);
    `CHK("product id", 16'h0c0d, d)
    cmd(0, 1'b1);
    cmd(1, 1'b0);
    `CHK("starts", 2, st_n)
    wr(16'hb612);
    alarm(6'h01, 2'b10);
    wr(16'hb617);
    wr(16'hb440);
    alarm(6'h08, 2'b10);
    $display("test commands done");
    wr(16'hb62f);
    @(posedge clock_i) ext_q[1] <= 1'b1;
    repeat (140) @(posedge clock_i);  // pulse beyond 2.6 us
    `CHK("no trig on rise", 0, trg_n)
    ext_q[1] <= 1'b0;
    repeat (10) @(posedge clock_i);
    `CHK("trig on fall", 1, trg_n)
    `CHK("trig lines", 2'b01, oe)
    wr(16'hb600);
    wr(16'hb801);
    wr(16'hb901);
    @(posedge clock_i) ext_q[1] <= 1'b1;
    repeat (4) @(posedge clock_i);
    `CHK("gpio pins", 4'b0101, {oe, out})
    rd(ADDR_GPIO_CONTROL);
    `CHK("gpio read", 16'h0301, d)
    $display("test lines done");
    close_out();
  end
endmodule : aiob_top_tb_top
